// File: rtl/lcp_map.svh
// Port addresses, field positions, reset values and codes of the cascaded controller
`ifndef LCP_MAP_SVH
`define LCP_MAP_SVH
`define LCP_MASTER_LO 8'h20
`define LCP_MASTER_HI 8'h21
`define LCP_SLAVE_LO 8'ha0
`define LCP_SLAVE_HI 8'ha1
`define LCP_INIT_WORD_ONE_BIT 4
`define LCP_OCW_SEL 4:3
`define LCP_EOI_PRIORITY_COMMAND_SEL 2'b00
`define LCP_POLL_READSEL_COMMAND_SEL 2'b01
`define LCP_CMD_FIELD 7:5
`define LCP_LEVEL_FIELD 2:0
`define LCP_SMM_FIELD 6:5
`define LCP_SMM_ON 2'b11
`define LCP_SMM_OFF 2'b10
`define LCP_POLL_BIT 2
`define LCP_RSEL_FIELD 1:0
`define LCP_RSEL_IRR 2'b10
`define LCP_RSEL_ISR 2'b11
`define LCP_VBASE_FIELD 7:3
`define LCP_CASCADE_LINE 3'd2
`define LCP_SPURIOUS_LINE 3'd7
`define LCP_MASK_RESET 8'h00
`define LCP_LOW_RESET 3'd7
`define LCP_VBASE_RESET 5'h00
`define LCP_DATA_RESET 8'h00
`define LCP_POLL_PAD 4'h0
`define LCP_MASTER 0
`define LCP_SLAVE 1
`endif

// File: rtl/lcp_pkg.sv
// Types shared by the cascaded interrupt controller
`default_nettype none
package lcp_pkg;
  typedef enum logic [1:0] {
    LCP_READY = 2'b00,
    LCP_WAIT_W2 = 2'b01,
    LCP_WAIT_W3 = 2'b10,
    LCP_WAIT_W4 = 2'b11
  } lcp_init_e;
  typedef enum logic [2:0] {
    LCP_CMD_NS_EOI = 3'b001,
    LCP_CMD_NOP = 3'b010,
    LCP_CMD_SP_EOI = 3'b011,
    LCP_CMD_ROT_NS = 3'b101,
    LCP_CMD_SET_PRIO = 3'b110,
    LCP_CMD_ROT_SP = 3'b111
  } lcp_cmd_e;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lcp_io_req_s;
  typedef struct packed {
    logic valid;
    logic [2:0] level;
  } lcp_grant_s;
endpackage
`default_nettype wire

// File: rtl/lcp_edge.sv
// Request register of one unit: edge capture or level follow per line
`timescale 1ns/1ps
`default_nettype none
module lcp_edge (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Request lines
  input wire logic [7:0] irq,
  input wire logic [7:0] level_sel,
  input wire logic [7:0] clr,
  // Request register
  output logic [7:0] irr
);
  logic [7:0] prev_q;
  logic [7:0] edge_q;
  logic [7:0] rise;
  logic [7:0] edge_d;

  assign rise = irq & ~prev_q;
  // Set beats clear so a new edge on the acknowledged line survives
  assign edge_d = (edge_q & ~clr) | rise;
  assign irr = (level_sel & irq) | (~level_sel & edge_q);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_q <= 8'h00;
      edge_q <= 8'h00;
    end else begin
      prev_q <= irq;
      edge_q <= edge_d;
    end
  end
endmodule
`default_nettype wire

// File: rtl/lcp_resolve.sv
// Rotating-priority resolver of one unit
`timescale 1ns/1ps
`default_nettype none
module lcp_resolve (
  // Unit state
  input wire logic [7:0] req,
  input wire logic [7:0] isr,
  input wire logic special_mask_value,
  input wire logic [2:0] low,
  // Results
  output lcp_pkg::lcp_grant_s grant,
  output lcp_pkg::lcp_grant_s top_isr
);
  import lcp_pkg::*;

  // Scan from the line just above the lowest-priority one
  function automatic lcp_grant_s first_after(input logic [7:0] v, input logic [2:0] lo);
    lcp_grant_s g;
    logic [2:0] idx;
    g = '0;
    idx = 3'd0;
    for (int i = 8; i >= 1; i--) begin
      idx = lo + 3'(i);
      if (v[idx]) begin
        g.valid = 1'b1;
        g.level = idx;
      end
    end
    return g;
  endfunction

  function automatic logic [2:0] rank(input logic [2:0] lvl, input logic [2:0] lo);
    return 3'(lvl - lo - 3'd1);
  endfunction

  logic [7:0] eff_req;
  lcp_grant_s r;
  lcp_grant_s s;
  logic beats_isr;

  // Special mask mode lets lower levels through while a level is in service
  assign eff_req = special_mask_value ? (req & ~isr) : req;
  assign r = first_after(eff_req, low);
  assign s = first_after(isr, low);
  assign beats_isr = special_mask_value | !s.valid | (rank(r.level, low) < rank(s.level, low));
  assign grant.valid = r.valid & beats_isr;
  assign grant.level = r.level;
  assign top_isr = s;
endmodule
`default_nettype wire

// File: rtl/lcp_pic.sv
// Cascaded master/slave programmable interrupt controller
`include "lcp_map.svh"
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module lcp_pic (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // IO bus
  input wire lcp_pkg::lcp_io_req_s io_req,
  output logic [7:0] io_rdata_q,
  output logic io_rdata_valid_q,
  // Interrupt acknowledge
  input wire logic inta,
  output logic [7:0] vector_q,
  output logic vector_valid_q,
  // Request lines
  input wire logic [15:0] irq,
  input wire logic [15:0] level_sel,
  // Interrupt to processor
  output logic intr_q
);
  import lcp_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [7:0] port_addr(input logic slave, input logic upper);
    logic [7:0] a;
    a = `LCP_MASTER_LO;
    case ({slave, upper})
      2'b00: a = `LCP_MASTER_LO;
      2'b01: a = `LCP_MASTER_HI;
      2'b10: a = `LCP_SLAVE_LO;
      2'b11: a = `LCP_SLAVE_HI;
      default: a = `LCP_MASTER_LO;
    endcase
    return a;
  endfunction

  function automatic logic [7:0] onehot(input logic [2:0] lvl);
    return 8'(8'h01 << lvl);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Cross-unit signals

  lcp_grant_s [1:0] grant;
  logic [1:0] ack_in;
  logic [1:0] poll_rd;
  logic [1:0] unit_rd_hit;
  logic [1:0][7:0] unit_rdata;
  logic [1:0][4:0] unit_vbase;
  logic master_to_slave;
  logic [7:0] rdata_d;
  logic [7:0] vector_d;

  // slave granted through master line two
  assign master_to_slave = grant[`LCP_MASTER].valid
    & (grant[`LCP_MASTER].level == `LCP_CASCADE_LINE);
  assign ack_in[`LCP_MASTER] = inta | poll_rd[`LCP_MASTER];
  assign ack_in[`LCP_SLAVE] = (inta & master_to_slave) | poll_rd[`LCP_SLAVE];

  //////////////////////////////////////////////////////////////////////////////
  // Units

  for (genvar u = 0; u < 2; u++) begin : unit
    lcp_init_e state_q;
    lcp_init_e state_d;
    logic [7:0] mask_q;
    logic [7:0] isr_q;
    logic [7:0] isr_d;
    logic [2:0] low_q;
    logic [2:0] low_d;
    logic [4:0] vbase_q;
    logic smm_q;
    logic rsel_isr_q;
    logic poll_q;
    logic wr_lo;
    logic wr_hi;
    logic rd_lo;
    logic rd_hi;
    logic is_init1;
    logic is_cmd2;
    logic is_cmd3;
    logic ready;
    logic [2:0] cmd;
    logic [2:0] tgt;
    logic [7:0] eoi_clr;
    logic [7:0] ack_set;
    logic [7:0] irr;
    logic [7:0] u_irq;
    logic [7:0] u_lvl;
    lcp_grant_s top_isr;

    // Address decode
    assign wr_lo = io_req.wr & (io_req.addr == port_addr(1'(u), 1'b0));
    assign wr_hi = io_req.wr & (io_req.addr == port_addr(1'(u), 1'b1));
    assign rd_lo = io_req.rd & (io_req.addr == port_addr(1'(u), 1'b0));
    assign rd_hi = io_req.rd & (io_req.addr == port_addr(1'(u), 1'b1));

    assign is_init1 = wr_lo & io_req.wdata[`LCP_INIT_WORD_ONE_BIT];
    assign is_cmd2 = wr_lo & (io_req.wdata[`LCP_OCW_SEL] == `LCP_EOI_PRIORITY_COMMAND_SEL);
    // mask mode, poll and readback word
    assign is_cmd3 = wr_lo & (io_req.wdata[`LCP_OCW_SEL] == `LCP_POLL_READSEL_COMMAND_SEL);
    assign ready = (state_q == LCP_READY);
    assign cmd = io_req.wdata[`LCP_CMD_FIELD];
    assign tgt = io_req.wdata[`LCP_LEVEL_FIELD];

    // fourth word contents are not stored
    always_comb begin
      state_d = state_q;
      case (state_q)
        LCP_READY: state_d = LCP_READY;
        LCP_WAIT_W2: if (wr_hi) state_d = LCP_WAIT_W3;
        LCP_WAIT_W3: if (wr_hi) state_d = LCP_WAIT_W4;
        LCP_WAIT_W4: if (wr_hi) state_d = LCP_READY;
        default: state_d = LCP_READY;
      endcase
      if (is_init1) begin
        state_d = LCP_WAIT_W2;
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        state_q <= LCP_READY;
      end else begin
        state_q <= state_d;
      end
    end

    // Only the vector base of the second word matters here
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        vbase_q <= `LCP_VBASE_RESET;
      end else if (wr_hi && state_q == LCP_WAIT_W2) begin
        vbase_q <= io_req.wdata[`LCP_VBASE_FIELD];
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        mask_q <= `LCP_MASK_RESET;
      end else if (is_init1) begin
        mask_q <= `LCP_MASK_RESET;
      end else if (wr_hi && ready) begin
        mask_q <= io_req.wdata;
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        smm_q <= 1'b0;
      end else if (is_init1) begin
        smm_q <= 1'b0;
      end else if (is_cmd3 && io_req.wdata[`LCP_SMM_FIELD] == `LCP_SMM_ON) begin
        smm_q <= 1'b1;
      end else if (is_cmd3 && io_req.wdata[`LCP_SMM_FIELD] == `LCP_SMM_OFF) begin
        smm_q <= 1'b0;
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        rsel_isr_q <= 1'b0;
      end else if (is_init1) begin
        rsel_isr_q <= 1'b0;
      end else if (is_cmd3 && io_req.wdata[`LCP_RSEL_FIELD] == `LCP_RSEL_ISR) begin
        rsel_isr_q <= 1'b1;
      end else if (is_cmd3 && io_req.wdata[`LCP_RSEL_FIELD] == `LCP_RSEL_IRR) begin
        rsel_isr_q <= 1'b0;
      end
    end

    // poll armed until the next read
    assign poll_rd[u] = (rd_lo | rd_hi) & poll_q;
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        poll_q <= 1'b0;
      end else if (is_init1) begin
        poll_q <= 1'b0;
      end else if (is_cmd3) begin
        poll_q <= io_req.wdata[`LCP_POLL_BIT];
      end else if (poll_rd[u]) begin
        poll_q <= 1'b0;
      end
    end

    // EOI and rotation commands; 000b, 010b and 100b do nothing
    always_comb begin
      eoi_clr = 8'h00;
      low_d = low_q;
      if (is_cmd2) begin
        case (cmd)
          LCP_CMD_NS_EOI: begin
            if (top_isr.valid) eoi_clr = onehot(top_isr.level);
          end
          LCP_CMD_SP_EOI: eoi_clr = onehot(tgt);
          LCP_CMD_ROT_NS: begin
            if (top_isr.valid) begin
              eoi_clr = onehot(top_isr.level);
              low_d = top_isr.level;
            end
          end
          LCP_CMD_SET_PRIO: low_d = tgt;
          LCP_CMD_ROT_SP: begin
            eoi_clr = onehot(tgt);
            low_d = tgt;
          end
          default: low_d = low_q;
        endcase
      end
      if (is_init1) begin
        low_d = `LCP_LOW_RESET;
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        low_q <= `LCP_LOW_RESET;
      end else begin
        low_q <= low_d;
      end
    end

    assign ack_set = (ack_in[u] && grant[u].valid) ? onehot(grant[u].level) : 8'h00;
    // Set beats clear so a grant is never lost to a same-cycle EOI
    assign isr_d = is_init1 ? 8'h00 : ((isr_q & ~eoi_clr) | ack_set);

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        isr_q <= 8'h00;
      end else begin
        isr_q <= isr_d;
      end
    end

    // slave output enters master line two as a level
    assign u_irq = (u == `LCP_MASTER)
      ? {irq[7:3], grant[`LCP_SLAVE].valid, irq[1:0]} : irq[15:8];
    assign u_lvl = (u == `LCP_MASTER)
      ? {level_sel[7:3], 1'b1, level_sel[1:0]} : level_sel[15:8];

    lcp_edge u_edge (
      .clk(clk),
      .reset_n(reset_n),
      .irq(u_irq),
      .level_sel(u_lvl),
      .clr(ack_set),
      .irr(irr)
    );

    // master mask bit two gates whole slave
    lcp_resolve u_resolve (
      .req(ready ? (irr & ~mask_q) : 8'h00),
      .isr(isr_q),
      .special_mask_value(smm_q),
      .low(low_q),
      .grant(grant[u]),
      .top_isr(top_isr)
    );

    // Readback per unit
    assign unit_rd_hit[u] = rd_lo | rd_hi;
    assign unit_vbase[u] = vbase_q;
    assign unit_rdata[u] = poll_q
      ? {grant[u].valid, `LCP_POLL_PAD, grant[u].level}
      : (rd_hi ? mask_q : (rsel_isr_q ? isr_q : irr));
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Unmapped reads answer zero so the bus never hangs
  assign rdata_d = unit_rd_hit[`LCP_MASTER] ? unit_rdata[`LCP_MASTER]
    : (unit_rd_hit[`LCP_SLAVE] ? unit_rdata[`LCP_SLAVE] : `LCP_DATA_RESET);

  assign vector_d = !grant[`LCP_MASTER].valid
    ? {unit_vbase[`LCP_MASTER], `LCP_SPURIOUS_LINE}
    : (master_to_slave
      ? {unit_vbase[`LCP_SLAVE], grant[`LCP_SLAVE].level}
      : {unit_vbase[`LCP_MASTER], grant[`LCP_MASTER].level});

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      io_rdata_q <= `LCP_DATA_RESET;
      io_rdata_valid_q <= 1'b0;
    end else begin
      io_rdata_q <= io_req.rd ? rdata_d : io_rdata_q;
      io_rdata_valid_q <= io_req.rd;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vector_q <= `LCP_DATA_RESET;
      vector_valid_q <= 1'b0;
    end else begin
      vector_q <= inta ? vector_d : vector_q;
      vector_valid_q <= inta;
    end
  end

  // Registered request to the processor, one cycle behind the resolver
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      intr_q <= 1'b0;
    end else begin
      intr_q <= grant[`LCP_MASTER].valid;
    end
  end
endmodule
`default_nettype wire

// File: sim/lcp_pic_properties.sv
// Port assertions of the cascaded interrupt controller
`include "lcp_map.svh"
`timescale 1ns/1ps
`default_nettype none
module lcp_pic_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // IO bus
  input wire lcp_pkg::lcp_io_req_s io_req,
  input wire logic [7:0] io_rdata_q,
  input wire logic io_rdata_valid_q,
  // Acknowledge
  input wire logic inta,
  input wire logic [7:0] vector_q,
  input wire logic vector_valid_q,
  // Requests and interrupt
  input wire logic [15:0] irq,
  input wire logic [15:0] level_sel,
  input wire logic intr_q
);
  import lcp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  sequence s_read;
    io_req.rd;
  endsequence
  sequence s_answer;
    io_rdata_valid_q;
  endsequence
  sequence s_unmapped;
    io_req.rd && !(io_req.addr inside
      {`LCP_MASTER_LO, `LCP_MASTER_HI, `LCP_SLAVE_LO, `LCP_SLAVE_HI});
  endsequence
  // Master init word 1; intr_q lags one cycle
  sequence s_init_start;
    io_req.wr && io_req.addr == `LCP_MASTER_LO && io_req.wdata[`LCP_INIT_WORD_ONE_BIT];
  endsequence
  AST_READ_ANSWER:
    assert property (s_read |=> s_answer) else $error("read without answer");
  AST_ANSWER_CAUSE:
    assert property (s_answer |-> $past(io_req.rd)) else $error("answer without read");
  AST_RDATA_HOLD:
    assert property (!io_req.rd |=> $stable(io_rdata_q)) else $error("read data moved");
  AST_UNMAPPED_ZERO:
    assert property (s_unmapped |=> io_rdata_q == 8'h00) else $error("unmapped read not zero");
  AST_ACK_VALID:
    assert property (inta |=> vector_valid_q) else $error("acknowledge without vector");
  AST_ACK_CAUSE:
    assert property (vector_valid_q |-> $past(inta)) else $error("vector without acknowledge");
  AST_VECTOR_HOLD:
    assert property (!inta |=> $stable(vector_q)) else $error("vector moved");
  AST_INIT_QUIET:
    assert property (s_init_start |-> ##2 !intr_q [*3]) else $error("interrupt during init");
endmodule
bind lcp_pic lcp_pic_properties i_lcp_pic_properties (
  .clk(clk), .reset_n(reset_n), .io_req(io_req), .io_rdata_q(io_rdata_q),
  .io_rdata_valid_q(io_rdata_valid_q), .inta(inta), .vector_q(vector_q),
  .vector_valid_q(vector_valid_q), .irq(irq), .level_sel(level_sel), .intr_q(intr_q));
`default_nettype wire

// File: sim/lcp_host.sv
// Host processor model: IO writes, reads and acknowledges
`timescale 1ns/1ps
`default_nettype none
module lcp_host (
  // Clock
  input wire logic clk,
  // IO bus
  output var lcp_pkg::lcp_io_req_s io_req,
  input wire logic [7:0] io_rdata_q,
  input wire logic io_rdata_valid_q,
  // Acknowledge
  output var logic inta,
  input wire logic [7:0] vector_q,
  input wire logic vector_valid_q
);
  import lcp_pkg::*;
  initial begin
    io_req = '0;
    inta = 1'b0;
  end
  ////////////////////////////////////////
  // Idle bus shows inverted lines so stale values never pass
  task automatic drive(input logic w, r, input logic [7:0] a, v);
    @(posedge clk);
    #1 io_req = {w, r, a, v};
    @(posedge clk);
    #1 io_req = {2'b00, ~a, ~v};
  endtask
  task automatic wr(input logic [7:0] a, v);
    drive(1'b1, 1'b0, a, v);
  endtask
  // No answer gives unknown data
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    drive(1'b0, 1'b1, a, ~a);
    v = io_rdata_valid_q ? io_rdata_q : 8'hxx;
  endtask
  task automatic ack(output logic [7:0] v);
    @(posedge clk);
    #1 inta = 1'b1;
    @(posedge clk);
    #1 inta = 1'b0;
    v = vector_valid_q ? vector_q : 8'hxx;
  endtask
  task automatic init(input logic [7:0] lo, base, w3, w4);
    wr(lo, 8'h11);
    wr(lo + 8'h01, base);
    wr(lo + 8'h01, w3);
    wr(lo + 8'h01, w4);
  endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench of the cascaded interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lcp_pkg::*;
  typedef struct {
    int line;
    logic [7:0] vec;
  } lcp_row_s;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] irq = '0;
  logic [15:0] level_sel = '0;
  lcp_io_req_s io_req;
  logic [7:0] io_rdata_q;
  logic [7:0] vector_q;
  logic [7:0] d;
  logic io_rdata_valid_q;
  logic vector_valid_q;
  logic inta;
  logic intr_q;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  lcp_row_s rows[5] = '{'{0, 8'h08}, '{3, 8'h0b}, '{7, 8'h0f}, '{9, 8'h71}, '{15, 8'h77}};
  always #50 clk = ~clk;
  lcp_pic i_lcp_pic (.clk(clk), .reset_n(reset_n), .io_req(io_req), .io_rdata_q(io_rdata_q),
    .io_rdata_valid_q(io_rdata_valid_q), .inta(inta), .vector_q(vector_q),
    .vector_valid_q(vector_valid_q), .irq(irq), .level_sel(level_sel), .intr_q(intr_q));
  lcp_host i_lcp_host (.clk(clk), .io_req(io_req), .io_rdata_q(io_rdata_q),
    .io_rdata_valid_q(io_rdata_valid_q), .inta(inta), .vector_q(vector_q),
    .vector_valid_q(vector_valid_q));
  ////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, v);
    i_lcp_host.wr(a, v);
  endtask
  task automatic rdc(input logic [7:0] a, exp);
    i_lcp_host.rd(a, d);
    check($sformatf("port %h", a), d, exp);
  endtask
  task automatic ackc(input logic [7:0] exp);
    i_lcp_host.ack(d);
    check("vector", d, exp);
  endtask
  // Three edges cover capture plus the registered output
  task automatic intrc(input logic exp);
    repeat (3) @(posedge clk);
    #1 check("intr", {7'h00, intr_q}, {7'h00, exp});
  endtask
  // Run is about two hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      report_and_stop;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
    rdc(8'h21, 8'h00);
    rdc(8'h10, 8'h00);
    i_lcp_host.init(8'h20, 8'h08, 8'h04, 8'h03);
    i_lcp_host.init(8'ha0, 8'h70, 8'h02, 8'h01);
    foreach (rows[i]) begin
      irq[rows[i].line] = 1'b1;
      intrc(1'b1);
      ackc(rows[i].vec);
      irq[rows[i].line] = 1'b0;
      if (rows[i].line > 7) begin
        wr(8'ha0, 8'h20);
      end
      wr(8'h20, 8'h20);
    end
    irq[1] = 1'b1;
    irq[4] = 1'b1;
    intrc(1'b1);
    ackc(8'h09);
    wr(8'h20, 8'h0b);
    rdc(8'h20, 8'h02);
    wr(8'h20, 8'h0a);
    rdc(8'h20, 8'h10);
    intrc(1'b0);
    wr(8'h20, 8'h68);
    intrc(1'b1);
    ackc(8'h0c);
    wr(8'h20, 8'h48);
    wr(8'h20, 8'h64);
    wr(8'h20, 8'h0b);
    rdc(8'h20, 8'h02);
    wr(8'h20, 8'he1);
    irq[0] = 1'b1;
    irq[3] = 1'b1;
    intrc(1'b1);
    ackc(8'h0b);
    wr(8'h20, 8'ha0);
    ackc(8'h08);
    wr(8'h20, 8'h40);
    wr(8'h20, 8'h00);
    wr(8'h20, 8'h80);
    rdc(8'h20, 8'h01);
    wr(8'h20, 8'hc7);
    wr(8'h20, 8'h20);
    rdc(8'h20, 8'h00);
    irq = '0;
    // Nothing pending: spurious vector, nothing in service
    ackc(8'h0f);
    rdc(8'h20, 8'h00);
    // Level line keeps its request through the acknowledge
    level_sel[6] = 1'b1;
    irq[6] = 1'b1;
    intrc(1'b1);
    ackc(8'h0e);
    wr(8'h20, 8'h0a);
    rdc(8'h20, 8'h40);
    irq[6] = 1'b0;
    wr(8'h20, 8'h20);
    wr(8'h20, 8'h0b);
    rdc(8'h20, 8'h00);
    wr(8'h21, 8'h04);
    rdc(8'h21, 8'h04);
    irq[8] = 1'b1;
    intrc(1'b0);
    wr(8'h21, 8'h01);
    intrc(1'b1);
    ackc(8'h70);
    wr(8'ha0, 8'h20);
    wr(8'h20, 8'h20);
    irq[0] = 1'b1;
    intrc(1'b0);
    irq[5] = 1'b1;
    wr(8'h20, 8'h0c);
    rdc(8'h20, 8'h85);
    rdc(8'h20, 8'h20);
    wr(8'h21, 8'hff);
    i_lcp_host.init(8'h20, 8'h08, 8'h04, 8'h03);
    rdc(8'h21, 8'h00);
    // Mid-run reset while a request is pending
    @(posedge clk);
    #1 irq = '0;
    reset_n = 1'b0;
    #1 check("intr", {7'h00, intr_q}, 8'h00);
    check("vector", vector_q, 8'h00);
    check("rdata", io_rdata_q, 8'h00);
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    rdc(8'h20, 8'h00);
    rdc(8'h21, 8'h00);
    intrc(1'b0);
    report_and_stop;
  end
endmodule
`default_nettype wire
